// >>> shared/upic_pkg.sv
// Package for the USB peripheral interrupt and mode control block.
// Assumes a 10 MHz core clock and a 16-bit parallel register port with byte strobes.
package upic_pkg;

    // Register offsets on the parallel port
    localparam logic [7:0] OFF_MODE = 8'h0c;
    localparam logic [7:0] OFF_IRQ_CFG = 8'h10;
    localparam logic [7:0] OFF_USB_STAT = 8'h18;
    localparam logic [7:0] OFF_USB_EN = 8'h14;
    localparam logic [7:0] OFF_DMA_STAT = 8'h50;
    localparam logic [7:0] OFF_DMA_EN = 8'h54;
    localparam logic [7:0] OFF_UNLOCK = 8'h7c;

    // Mode register fields
    localparam int MODE_PULLUP_BIT = 0;
    localparam int MODE_GATE_BIT = 3;
    localparam int MODE_KEEPALIVE_BIT = 7;
    localparam logic [15:0] MODE_RESET = 16'h0000;

    // Interrupt configuration fields
    localparam int CFG_POL_BIT = 0;
    localparam int CFG_LVL_BIT = 1;
    localparam int CFG_CTRL_LSB = 2;
    localparam int CFG_IN_LSB = 4;
    localparam int CFG_OUT_LSB = 6;
    localparam logic [7:0] CFG_RESET = 8'h00;

    localparam logic [15:0] UNLOCK_CODE = 16'haa37;

    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int PULSE_NS = 60;
    localparam int PULSE_CYCLES = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_MIN_US = 500;
    localparam int POWERUP_RESET_MS = 2;

    // Pipe interrupt policy codes
    typedef enum logic [1:0] {
        POL_ACK = 2'b00,
        POL_ACK_NAK = 2'b01,
        POL_ACK_NAK1 = 2'b10,
        POL_RSVD = 2'b11
    } upic_policy_t;

    // Register read or write request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [1:0] be;
        logic [15:0] wdata;
    } upic_req_t;

    // Raw pipe event inputs
    typedef struct packed {
        logic ack;
        logic nak;
    } upic_pipe_ev_t;

endpackage : upic_pkg

// >>> verilog/upic_pulse_gen.sv
// One-shot pulse generator for the interrupt pin.
// Assumes a synchronous trigger on mclk.
`timescale 1ns/1ps
module upic_pulse_gen
    import upic_pkg::*;
#(
    parameter int CYCLES = PULSE_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Trigger and output
    input wire logic trig,
    output logic pulse
);
    logic [7:0] cnt;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 8'h00;
        end else if (trig) begin
            cnt <= 8'(CYCLES);
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end
    end

    assign pulse = (cnt != 8'h00);

endmodule : upic_pulse_gen

// >>> verilog/upic_stat_reg.sv
// Sticky event status with write-one-to-clear and enable gating.
// Assumes events are one-cycle pulses synchronous to mclk.
`timescale 1ns/1ps
module upic_stat_reg
    import upic_pkg::*;
#(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Events and controls
    input wire logic [W-1:0] ev,
    input wire logic [W-1:0] clr,
    input wire logic [W-1:0] en,
    // State
    output logic [W-1:0] stat,
    output logic pend
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    stat[i] <= 1'b0;
                end else if (ev[i]) begin
                    stat[i] <= 1'b1; // Set wins over clear
                end else if (clr[i]) begin
                    stat[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign pend = |(stat & en);

endmodule : upic_stat_reg

// >>> verilog/upic_irq_mode_ctrl.sv
// Summary of operation
// - Polarity and level/pulse bits of register 10h steer the interrupt pin.
// - Interrupt pin goes active only when the global gate bit is set.
// - After reset the pin is active low and level signaled.
// - Pulse mode gives one 100 ns (one mclk) pulse per rise of pending status OR.
// - Each DMA event and each USB event below the top three pipe bits sets its own status bit.
// - Only enabled status bits contribute to the interrupt.
// - Three 2-bit policies select which pipe events raise interrupts.
// - With gate clear, events still log but do not activate the pin.
// - Level mode: setting the gate with pending status asserts at once.
// - Level mode: clearing gate while asserted keeps pin asserted while pending.
// - Level interrupt deasserts only when all pending status is cleared.
// - Pull-up pin follows the attach bit; hardware reset clears it.
// - USB bus reset leaves the attach bit alone.
// - After resume wake-up, register writes blocked until unlock code written.
// - Suspended with keep-alive clear, a bus power edge restarts the clock.
// Top of the interrupt and mode control; register port is synchronous to mclk.
`timescale 1ns/1ps
module upic_irq_mode_ctrl
    import upic_pkg::*;
#(
    parameter int USB_EV_W = 16,
    parameter int DMA_EV_W = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire upic_req_t req,
    output logic [15:0] rdata,
    // Events from protocol engine and DMA
    input wire logic [USB_EV_W-1:0] usb_ev,
    input wire logic [DMA_EV_W-1:0] dma_ev,
    input wire upic_pipe_ev_t ctrl_ev,
    input wire upic_pipe_ev_t in_ev,
    input wire upic_pipe_ev_t out_ev,
    input wire logic first_nak,
    // Power management
    input wire logic suspended,
    input wire logic resume_wake,
    input wire logic vbus_sense,
    // Pins and outputs
    output logic irq_pin,
    output logic pullup_resistor_pin,
    output logic clk_wake,
    output logic write_locked
);
    localparam int PIPE_BITS = 3;

    logic [15:0] mode;
    logic [7:0] cfg;
    logic [USB_EV_W-1:0] usb_en;
    logic [DMA_EV_W-1:0] dma_en;
    logic [USB_EV_W-1:0] usb_stat;
    logic [DMA_EV_W-1:0] dma_stat;
    logic usb_pend;
    logic dma_pend;
    logic any_pend;
    logic any_pend_d;
    logic pulse;
    logic level_act;
    logic vbus_d;
    logic vbus_seen;
    logic wr_ok;
    logic [USB_EV_W-1:0] usb_clr;
    logic [DMA_EV_W-1:0] dma_clr;
    logic [USB_EV_W-1:0] usb_all;
    logic [PIPE_BITS-1:0] pipe_ev;

    wire logic irq_polarity_sel = cfg[CFG_POL_BIT];
    wire logic irq_signal_mode_sel = cfg[CFG_LVL_BIT];
    wire logic global_irq_gate = mode[MODE_GATE_BIT];
    wire logic pullup_attach = mode[MODE_PULLUP_BIT];
    wire logic clock_keep_alive = mode[MODE_KEEPALIVE_BIT];
    wire upic_policy_t ctrl_pipe_irq_policy = upic_policy_t'(cfg[CFG_CTRL_LSB +: 2]);
    wire upic_policy_t in_pipe_irq_policy = upic_policy_t'(cfg[CFG_IN_LSB +: 2]);
    wire upic_policy_t out_pipe_irq_policy = upic_policy_t'(cfg[CFG_OUT_LSB +: 2]);

    // Policy decides which handshakes of a pipe count as an event
    function automatic logic pipe_hit(input upic_policy_t pol, input upic_pipe_ev_t e, input logic first);
        case (pol)
            POL_ACK: pipe_hit = e.ack;
            POL_ACK_NAK: pipe_hit = e.ack | e.nak;
            POL_ACK_NAK1: pipe_hit = e.ack | (e.nak & first);
            default: pipe_hit = e.ack;
        endcase
    endfunction : pipe_hit

    // Byte-lane write data merge
    function automatic logic [15:0] merge(input logic [15:0] old, input upic_req_t r);
        merge = old;
        if (r.be[0]) begin
            merge[7:0] = r.wdata[7:0];
        end
        if (r.be[1]) begin
            merge[15:8] = r.wdata[15:8];
        end
    endfunction : merge

    function automatic logic hit(input upic_req_t r, input logic [7:0] off);
        hit = r.wr && (r.addr == off);
    endfunction : hit

    assign pipe_ev[0] = pipe_hit(ctrl_pipe_irq_policy, ctrl_ev, first_nak);
    assign pipe_ev[1] = pipe_hit(in_pipe_irq_policy, in_ev, first_nak);
    assign pipe_ev[2] = pipe_hit(out_pipe_irq_policy, out_ev, first_nak);
    // Pipe events occupy the top three USB status bits
    assign usb_all = usb_ev | {pipe_ev, {(USB_EV_W-PIPE_BITS){1'b0}}};

    // Unlock write is accepted unless resume_wake comes in the same cycle; others wait for the lock to lift
    assign wr_ok = !write_locked;

    // Lone byte writes still clear only their own byte; firmware should write both
    assign usb_clr = (wr_ok && hit(req, OFF_USB_STAT)) ?
        USB_EV_W'(merge(16'h0000, req)) : '0;
    assign dma_clr = (wr_ok && hit(req, OFF_DMA_STAT)) ?
        DMA_EV_W'(merge(16'h0000, req)) : '0;

    upic_stat_reg #(.W(USB_EV_W)) u_usb_stat (
        .mclk(mclk),
        .rst_n(rst_n),
        .ev(usb_all),
        .clr(usb_clr),
        .en(usb_en),
        .stat(usb_stat),
        .pend(usb_pend)
    );

    upic_stat_reg #(.W(DMA_EV_W)) u_dma_stat (
        .mclk(mclk),
        .rst_n(rst_n),
        .ev(dma_ev),
        .clr(dma_clr),
        .en(dma_en),
        .stat(dma_stat),
        .pend(dma_pend)
    );

    assign any_pend = usb_pend | dma_pend;

    // Write lock
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            write_locked <= 1'b0;
        end else if (resume_wake) begin
            write_locked <= 1'b1;
        end else if (hit(req, OFF_UNLOCK) && req.be == 2'b11 && req.wdata == UNLOCK_CODE) begin
            write_locked <= 1'b0;
        end
    end

    // Mode register; bus reset has no input here so it cannot touch attach
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= MODE_RESET;
        end else if (wr_ok && hit(req, OFF_MODE)) begin
            mode <= merge(mode, req);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= CFG_RESET;
        end else if (wr_ok && hit(req, OFF_IRQ_CFG) && req.be[0]) begin
            cfg <= req.wdata[7:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            usb_en <= '0;
            dma_en <= '0;
        end else if (wr_ok) begin
            if (hit(req, OFF_USB_EN)) begin
                usb_en <= USB_EV_W'(merge(16'(usb_en), req));
            end
            if (hit(req, OFF_DMA_EN)) begin
                dma_en <= DMA_EV_W'(merge(16'(dma_en), req));
            end
        end
    end

    // Read back
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 16'h0000;
        end else if (req.rd) begin
            case (req.addr)
                OFF_MODE: rdata <= mode;
                OFF_IRQ_CFG: rdata <= {8'h00, cfg};
                OFF_USB_EN: rdata <= 16'(usb_en);
                OFF_USB_STAT: rdata <= 16'(usb_stat);
                OFF_DMA_EN: rdata <= 16'(dma_en);
                OFF_DMA_STAT: rdata <= 16'(dma_stat);
                OFF_UNLOCK: rdata <= {15'h0000, write_locked};
                default: rdata <= 16'h0000;
            endcase
        end
    end

    // Pulse trigger on rise of the pending OR
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            any_pend_d <= 1'b0;
        end else begin
            any_pend_d <= any_pend;
        end
    end

    upic_pulse_gen #(.CYCLES(PULSE_CYCLES)) u_pulse (
        .mclk(mclk),
        .rst_n(rst_n),
        .trig(any_pend && !any_pend_d && global_irq_gate),
        .pulse(pulse)
    );

    // Level hold: gate opens assertion, pending alone keeps it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            level_act <= 1'b0;
        end else if (!any_pend) begin
            level_act <= 1'b0;
        end else if (global_irq_gate) begin
            level_act <= 1'b1;
        end
    end // Gate clear leaves level_act alone

    // Pin drive; idle level is the inverse of the active polarity
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_pin <= 1'b1;
        end else begin
            irq_pin <= (irq_signal_mode_sel ? pulse : level_act) ^ ~irq_polarity_sel;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pullup_resistor_pin <= 1'b0;
        end else begin
            pullup_resistor_pin <= pullup_attach;
        end
    end

    // Clock wake request on bus power transition
    // No history at the first edge after reset, so a powered bus there is no false edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            vbus_d <= 1'b0;
            vbus_seen <= 1'b0;
            clk_wake <= 1'b0;
        end else begin
            vbus_d <= vbus_sense;
            vbus_seen <= 1'b1;
            clk_wake <= suspended && !clock_keep_alive && vbus_seen && (vbus_sense != vbus_d);
        end
    end

    // Steps of the two signalling modes
    sequence s_pend_gate;
        any_pend && global_irq_gate && !irq_signal_mode_sel;
    endsequence

    sequence s_pend_rise;
        any_pend && !any_pend_d && global_irq_gate && irq_signal_mode_sel;
    endsequence

    // Level signalling and the global gate
    a_level_assert: assert property (@(posedge mclk) disable iff (!rst_n)
        s_pend_gate |-> ##2 (irq_pin == $past(irq_polarity_sel) || $past(irq_signal_mode_sel)))
        else $error("level irq not asserted");
    a_gate_blocks: assert property (@(posedge mclk) disable iff (!rst_n)
        (!global_irq_gate && !level_act && $rose(any_pend)) |=> !pulse)
        else $error("pulse while gate closed");
    a_level_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        (level_act && any_pend && $fell(global_irq_gate)) |=> level_act)
        else $error("level dropped on gate clear");
    a_level_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        !any_pend |=> !level_act)
        else $error("level irq without pending");
    a_level_mask: assert property (@(posedge mclk) disable iff (!rst_n)
        (!level_act && !global_irq_gate) |=> !level_act)
        else $error("level irq opened with gate closed");
    a_level_cause: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(level_act) |-> ($past(global_irq_gate) && $past(any_pend)))
        else $error("level irq without gate and pending");
    a_pin_idle: assert property (@(posedge mclk) disable iff (!rst_n)
        (!level_act && !pulse) |=> (irq_pin == !$past(irq_polarity_sel)))
        else $error("irq pin not idle");

    // Pulse signalling
    a_pulse_width: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(pulse) |-> pulse[*1] ##1 !pulse)
        else $error("pulse width wrong");
    a_pulse_cause: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(pulse) |-> ($past(any_pend) && !$past(any_pend_d) && $past(global_irq_gate)))
        else $error("pulse without pending rise");
    a_pulse_pin: assert property (@(posedge mclk) disable iff (!rst_n)
        s_pend_rise |-> ##2 (irq_pin == $past(irq_polarity_sel) || !$past(irq_signal_mode_sel)))
        else $error("irq pulse missing on pin");

    // Status logging and clearing
    a_stat_set: assert property (@(posedge mclk) disable iff (!rst_n)
        usb_ev[0] |=> usb_stat[0])
        else $error("event not logged");
    a_usb_log: assert property (@(posedge mclk) disable iff (!rst_n)
        (usb_all != '0) |=> ((usb_stat & $past(usb_all)) == $past(usb_all)))
        else $error("usb event not logged");
    a_dma_log: assert property (@(posedge mclk) disable iff (!rst_n)
        (dma_ev != '0) |=> ((dma_stat & $past(dma_ev)) == $past(dma_ev)))
        else $error("dma event not logged");
    a_stat_keep: assert property (@(posedge mclk) disable iff (!rst_n)
        (usb_stat[0] && !usb_clr[0]) |=> usb_stat[0])
        else $error("status lost without clear");
    a_stat_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        (usb_clr[0] && !usb_all[0]) |=> !usb_stat[0])
        else $error("status not cleared");

    // Mode register, write lock and clock wake
    a_pullup_follow: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 pullup_resistor_pin == $past(pullup_attach))
        else $error("pullup pin mismatch");
    a_lock_blocks: assert property (@(posedge mclk) disable iff (!rst_n)
        (write_locked && hit(req, OFF_MODE)) |=> $stable(mode))
        else $error("write while locked");
    a_cfg_locked: assert property (@(posedge mclk) disable iff (!rst_n)
        (write_locked && hit(req, OFF_IRQ_CFG)) |=> $stable(cfg))
        else $error("config write while locked");
    a_wake_lock: assert property (@(posedge mclk) disable iff (!rst_n)
        resume_wake |=> write_locked)
        else $error("resume did not lock writes");
    a_unlock_code: assert property (@(posedge mclk) disable iff (!rst_n)
        (!resume_wake && hit(req, OFF_UNLOCK) && req.be == 2'b11 && req.wdata == UNLOCK_CODE) |=> !write_locked)
        else $error("unlock code ignored");
    a_wake_edge: assert property (@(posedge mclk) disable iff (!rst_n)
        (suspended && !clock_keep_alive && vbus_seen && $changed(vbus_sense)) |=> clk_wake)
        else $error("no clock wake");
    a_wake_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
        (!suspended || clock_keep_alive) |=> !clk_wake)
        else $error("clock wake while not allowed");

endmodule : upic_irq_mode_ctrl

// >>> dv/upic_host_model.sv
// Host processor model on the parallel register port of the interrupt block.
// Assumes requests launch 10 ns after a rising mclk edge and are taken at the next edge.
`timescale 1ns/1ps
module upic_host_model
    import upic_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Register port
    output upic_req_t req,
    input wire logic [15:0] rdata
);
    initial begin
        req = '0;
    end

    // Held for one edge, then released with inverted leftovers so stale values are never trusted
    task automatic xfer(input logic w, input logic [7:0] a, input logic [1:0] b, input logic [15:0] d,
                        output logic [15:0] q);
        @(posedge mclk);
        #10;
        req = '{wr: w, rd: !w, addr: a, be: b, wdata: d};
        @(posedge mclk);
        #10;
        q = rdata;
        req = '{wr: 1'b0, rd: 1'b0, addr: ~a, be: ~b, wdata: ~d};
    endtask : xfer

    // Status is acknowledged with both byte lanes, never a single byte
    task automatic ack_all(input logic [7:0] a);
        logic [15:0] q;
        xfer(1'b1, a, 2'b11, 16'hffff, q);
    endtask : ack_all
endmodule : upic_host_model

// >>> dv/test_usb_periph_irq_and_mode_ctrl.sv
// Self-checking bench for the interrupt and mode control block.
// Assumes the host model drives the register port; events and power pins come from here.
`timescale 1ns/1ps
module test_usb_periph_irq_and_mode_ctrl;
    import upic_pkg::*;
    logic mclk, rst_n, first_nak, suspended, resume_wake, vbus_sense;
    logic irq_pin, pullup_resistor_pin, clk_wake, write_locked;
    logic [15:0] rdata, usb_ev, dma_ev, q;
    upic_req_t req;
    upic_pipe_ev_t ctrl_ev, in_ev, out_ev;
    int miscompares, n_checks, n;

    upic_host_model host (.mclk(mclk), .req(req), .rdata(rdata));
    upic_irq_mode_ctrl dut (.mclk(mclk), .rst_n(rst_n), .req(req), .rdata(rdata), .usb_ev(usb_ev),
        .dma_ev(dma_ev), .ctrl_ev(ctrl_ev), .in_ev(in_ev), .out_ev(out_ev), .first_nak(first_nak),
        .suspended(suspended), .resume_wake(resume_wake), .vbus_sense(vbus_sense), .irq_pin(irq_pin),
        .pullup_resistor_pin(pullup_resistor_pin), .clk_wake(clk_wake), .write_locked(write_locked));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host.xfer(1'b1, a, 2'b11, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        host.xfer(1'b0, a, 2'b11, 16'h0000, q);
    endtask : rd

    // One-cycle event pulses; pe holds {ack,nak} for ctrl, in, out pipes from the bottom
    task automatic ev(input logic [15:0] u, input logic [15:0] d, input logic [5:0] pe);
        @(posedge mclk);
        #10;
        usb_ev = u;
        dma_ev = d;
        {out_ev, in_ev, ctrl_ev} = pe;
        @(posedge mclk);
        #10;
        usb_ev = '0;
        dma_ev = '0;
        {out_ev, in_ev, ctrl_ev} = '0;
    endtask : ev

    task automatic wait_pin(input logic lvl);
        n = 0;
        while (irq_pin !== lvl && n < 8) begin
            @(posedge mclk);
            #10;
            n++;
        end
        chk({15'h0, irq_pin}, {15'h0, lvl});
        if (irq_pin !== lvl) finish_test();
    endtask : wait_pin

    task automatic hold_pin(input logic lvl);
        repeat (6) begin
            @(posedge mclk);
            #10;
            chk({15'h0, irq_pin}, {15'h0, lvl});
        end
    endtask : hold_pin

    task automatic count_hi(input logic wake, output int c);
        c = 0;
        repeat (8) begin
            @(posedge mclk);
            #10;
            c += int'(wake ? clk_wake === 1'b1 : irq_pin === 1'b0);
        end
    endtask : count_hi

    initial begin
        rst_n = 1'b0;
        usb_ev = '0;
        dma_ev = '0;
        {out_ev, in_ev, ctrl_ev} = '0;
        first_nak = 1'b0;
        suspended = 1'b0;
        resume_wake = 1'b0;
        vbus_sense = 1'b1;
        miscompares = 0;
        n_checks = 0;
        // Reset far shorter than the real pulse width to keep the run small
        repeat (8) @(posedge mclk);
        #10;
        rst_n = 1'b1;
        chk({15'h0, irq_pin}, 16'h1);
        chk({15'h0, pullup_resistor_pin}, 16'h0);
        rd(OFF_MODE);
        chk(q, MODE_RESET);
        rd(OFF_IRQ_CFG);
        chk(q, {8'h0, CFG_RESET});
        // Gate closed: the event is logged but the pin stays quiet
        wr(OFF_USB_EN, 16'h0001);
        ev(16'h0001, 16'h0, 6'h0);
        hold_pin(1'b1);
        rd(OFF_USB_STAT);
        chk(q, 16'h0001);
        wr(OFF_MODE, 16'h0008);
        wait_pin(1'b0);
        wr(OFF_MODE, 16'h0000);
        hold_pin(1'b0);
        wr(OFF_USB_STAT, 16'hfffe);
        hold_pin(1'b0);
        host.ack_all(OFF_USB_STAT);
        wait_pin(1'b1);
        // Disabled DMA reason is logged, then signalled once enabled
        wr(OFF_MODE, 16'h0008);
        ev(16'h0, 16'h0004, 6'h0);
        hold_pin(1'b1);
        rd(OFF_DMA_STAT);
        chk(q, 16'h0004);
        wr(OFF_DMA_EN, 16'h0004);
        wait_pin(1'b0);
        wr(OFF_IRQ_CFG, 16'h0001);
        wait_pin(1'b1);
        host.ack_all(OFF_DMA_STAT);
        wait_pin(1'b0);
        // Pulse mode: one pulse per rise of the pending OR, none while it stays high
        wr(OFF_IRQ_CFG, 16'h0002);
        wait_pin(1'b1);
        ev(16'h0001, 16'h0, 6'h0);
        count_hi(1'b0, n);
        chk(16'(n), 16'(PULSE_CYCLES));
        ev(16'h0001, 16'h0, 6'h0);
        count_hi(1'b0, n);
        chk(16'(n), 16'h0);
        host.ack_all(OFF_USB_STAT);
        // Pipe policies: every code, every pipe, with and without the first-nak qualifier
        wr(OFF_IRQ_CFG, 16'h0000);
        wr(OFF_USB_EN, 16'he001);
        ev(16'h0, 16'h0, 6'h02);
        rd(OFF_USB_STAT);
        chk({15'h0, q[13]}, 16'h1);
        host.ack_all(OFF_USB_STAT);
        for (int p = 0; p < 3; p++) begin
            for (int c = 0; c < 4; c++) begin
                for (int f = 0; f < 2; f++) begin
                    wr(OFF_IRQ_CFG, 16'(c << (CFG_CTRL_LSB + 2 * p)));
                    first_nak = f[0];
                    ev(16'h0, 16'h0, 6'(1 << (2 * p)));
                    rd(OFF_USB_STAT);
                    chk({15'h0, q[13 + p]}, 16'(c == 1 || (c == 2 && f == 1)));
                    host.ack_all(OFF_USB_STAT);
                end
            end
        end
        // Write lock after resume
        wr(OFF_MODE, 16'h0000);
        @(posedge mclk);
        #10;
        resume_wake = 1'b1;
        @(posedge mclk);
        #10;
        resume_wake = 1'b0;
        wr(OFF_MODE, 16'h0001);
        rd(OFF_MODE);
        chk(q, 16'h0000);
        wr(OFF_IRQ_CFG, 16'h0003);
        rd(OFF_IRQ_CFG);
        chk(q, 16'h00c0);
        chk({15'h0, write_locked}, 16'h1);
        wr(OFF_UNLOCK, UNLOCK_CODE);
        wr(OFF_MODE, 16'h0001);
        rd(OFF_MODE);
        chk(q, 16'h0001);
        chk({15'h0, pullup_resistor_pin}, 16'h1);
        // Suspended with keep-alive clear: bus power loss wakes the clock
        suspended = 1'b1;
        vbus_sense = 1'b0;
        count_hi(1'b1, n);
        chk(16'(n), 16'h1);
        wr(OFF_MODE, 16'h0080);
        rd(OFF_MODE);
        chk(q, 16'h0080);
        chk({15'h0, pullup_resistor_pin}, 16'h0);
        vbus_sense = 1'b1;
        count_hi(1'b1, n);
        chk(16'(n), 16'h0);
        finish_test();
    end
endmodule : test_usb_periph_irq_and_mode_ctrl
